// ### src/tsec_pkg.sv
// constants, register map and helpers for the two-stage event controller
`default_nettype none
package tsec_pkg;

	// event levels: bit index is the level number, lower index wins
	localparam int NLEVEL = 16;
	localparam int LVL_W = 4;
	localparam int NPERIPH = 32;
	localparam int MAP_W = 4;
	localparam logic [3:0] LVL_EMU = 4'h0;
	localparam logic [3:0] LVL_RST = 4'h1;
	localparam logic [3:0] LVL_NMI = 4'h2;
	localparam logic [3:0] LVL_EXC = 4'h3;
	localparam logic [3:0] LVL_NONE = 4'hF;
	localparam logic [15:0] FIXED_BITS = 16'h000F;
	localparam logic [15:0] GEN_BITS = 16'hFF80;
	localparam logic [15:0] ALL_BITS = 16'hFFFF;

	// reset values
	localparam logic [15:0] CMASK_RST = 16'h0000;
	localparam logic [31:0] PMASK_RST = 32'h0000_0000;
	localparam logic [31:0] CTRL_RST = 32'h0000_0001;
	localparam logic [127:0] MAP_RST = 128'hDDD7_7777_7777_7777_7777_7777_7777_7777;

	// register byte offsets
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_LATCH = 8'h00;
	localparam logic [7:0] OFS_CMASK = 8'h04;
	localparam logic [7:0] OFS_ACTIVE = 8'h08;
	localparam logic [7:0] OFS_PMASK = 8'h0C;
	localparam logic [7:0] OFS_PSTATUS = 8'h10;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
	localparam logic [7:0] OFS_CTRL = 8'h1C;
	localparam logic [3:0] OFS_MAP_HI = 4'h3;

	// control and interrupt status bit positions
	localparam int CTRL_GEN_EN = 0;
	localparam int IRQ_W = 3;
	localparam int IRQ_DISPATCH = 0;
	localparam int IRQ_RETURN = 1;
	localparam int IRQ_OVERRUN = 2;

	// lowest set bit, LVL_NONE when empty
	function automatic logic [3:0] tsec_first(input logic [15:0] v);
		logic [3:0] r;
		r = LVL_NONE;
		for (int i = NLEVEL - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = i[3:0];
			end
		end
		return r;
	endfunction

endpackage
`default_nettype wire

// ### src/tsec_evt_if.sv
// carrier between the system stage and the core stage
`timescale 1ns/1ps
`default_nettype none
interface tsec_evt_if;
	logic [tsec_pkg::NPERIPH-1:0] pmask;
	logic [tsec_pkg::NPERIPH*tsec_pkg::MAP_W-1:0] map;
	logic [tsec_pkg::NLEVEL-1:0] gen_lines;
	logic [tsec_pkg::NPERIPH-1:0] pstatus;
	modport sys (input pmask, input map, output gen_lines, output pstatus);
	modport core (output pmask, output map, input gen_lines, input pstatus);
endinterface
`default_nettype wire

// ### src/tsec_sys_stage.sv
// system stage: peripheral masking, status and mapping onto core levels
`timescale 1ns/1ps
`default_nettype none
module tsec_sys_stage #(
	parameter int NPERIPH = tsec_pkg::NPERIPH,
	parameter int NLEVEL = tsec_pkg::NLEVEL,
	parameter int MAP_W = tsec_pkg::MAP_W
) (
	// peripheral requests, same clock domain
	input wire logic [NPERIPH-1:0] periph_irq,
	// link to the core stage
	tsec_evt_if.sys bus
);
	logic [NPERIPH-1:0] passed;
	logic [NLEVEL-1:0] lines;

	assign passed = periph_irq & bus.pmask;
	assign bus.pstatus = periph_irq;
	assign bus.gen_lines = lines;

	// several peripherals may share one level line
	always_comb begin
		lines = '0;
		for (int i = 0; i < NPERIPH; i++) begin
			if (passed[i]) begin
				lines[bus.map[i*MAP_W +: MAP_W]] = 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ### src/tsec_edge_latch.sv
// per-level rising edge detect and event latch
`timescale 1ns/1ps
`default_nettype none
module tsec_edge_latch #(
	parameter int W = tsec_pkg::NLEVEL
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// event sources
	input wire logic [W-1:0] evt_in,
	input wire logic [W-1:0] direct_set,
	// acceptance and software access
	input wire logic [W-1:0] take_clr,
	input wire logic wr_en,
	input wire logic [W-1:0] wr_sel,
	input wire logic [W-1:0] wr_data,
	// state
	output logic [W-1:0] latch,
	output logic overrun
);
	logic [W-1:0] in_q_reg;
	logic [W-1:0] det_reg;
	logic [W-1:0] latch_reg;
	logic [W-1:0] latch_next;
	logic [W-1:0] kept;
	logic [W-1:0] set_all;
	logic overrun_reg;

	assign set_all = det_reg | direct_set;
	assign kept = latch_reg & ~take_clr;
	assign latch_next = (wr_en ? ((kept & ~wr_sel) | (wr_data & wr_sel)) : kept) | set_all;
	assign latch = latch_reg;
	assign overrun = overrun_reg;

	// edge found in one cycle, latched the next: two cycles
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			in_q_reg <= '0;
			det_reg <= '0;
			latch_reg <= '0;
			overrun_reg <= 1'b0;
		end else begin
			in_q_reg <= evt_in;
			det_reg <= evt_in & ~in_q_reg;
			latch_reg <= latch_next;
			overrun_reg <= |(set_all & kept);
		end
	end
endmodule
`default_nettype wire

// ### src/tsec_top.sv
// core stage of the two-stage event controller with APB registers
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tsec_top (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [tsec_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// event sources
	input wire logic [tsec_pkg::NPERIPH-1:0] periph_irq,
	input wire logic wdog_nmi,
	input wire logic nmi_pin,
	input wire logic emu_pin,
	input wire logic reset_pin,
	input wire logic exc_req,
	input wire logic swi_req,
	input wire logic [tsec_pkg::LVL_W-1:0] swi_level,
	// sequencer side
	input wire logic core_ready,
	input wire logic [31:0] core_pc,
	input wire logic rte_valid,
	input wire logic [tsec_pkg::LVL_W-1:0] rte_level,
	output logic dispatch_valid,
	output logic [tsec_pkg::LVL_W-1:0] dispatch_level,
	output logic save_state_req,
	output logic core_reset,
	output logic emu_mode,
	output logic resume_valid,
	output logic [31:0] resume_pc,
	// interrupt output
	output logic irq
);
	tsec_evt_if evt_bus ();

	// pin synchronisers
	logic [1:0] nmi_sync_reg;
	logic [1:0] emu_sync_reg;
	logic [1:0] rst_sync_reg;

	// registers
	logic [15:0] cmask_reg;
	logic [15:0] active_reg;
	logic [15:0] active_next;
	logic [31:0] pmask_reg;
	logic [127:0] map_reg;
	logic [31:0] ctrl_reg;
	logic [tsec_pkg::IRQ_W-1:0] irq_stat_reg;
	logic [tsec_pkg::IRQ_W-1:0] irq_stat_next;
	logic [tsec_pkg::IRQ_W-1:0] irq_mask_reg;
	logic [31:0] ret_addr_reg [tsec_pkg::NLEVEL];

	// output registers
	logic dispatch_valid_reg;
	logic [3:0] dispatch_level_reg;
	logic core_reset_reg;
	logic emu_mode_reg;
	logic resume_valid_reg;
	logic [31:0] resume_pc_reg;

	// event path
	logic [15:0] evt_in;
	logic [15:0] direct_set;
	logic [15:0] latch;
	logic overrun;
	logic [15:0] cmask_eff;
	logic [15:0] gen_en_bits;
	logic [15:0] pending;
	logic [3:0] pend_lvl;
	logic [3:0] act_lvl;
	logic [15:0] pend_onehot;
	logic [15:0] rte_onehot;
	logic [15:0] take_clr;
	logic take;
	logic take_rst;
	logic take_emu;
	logic rte_emu;

	// bus decode
	logic acc;
	logic wr;
	logic sel_latch;
	logic sel_cmask;
	logic sel_active;
	logic sel_pmask;
	logic sel_pstatus;
	logic sel_irq_stat;
	logic sel_irq_mask;
	logic sel_ctrl;
	logic sel_map;
	logic hit;
	logic [1:0] map_idx;
	logic [31:0] map_word;

	// system stage
	tsec_sys_stage #(
		.NPERIPH(tsec_pkg::NPERIPH),
		.NLEVEL(tsec_pkg::NLEVEL),
		.MAP_W(tsec_pkg::MAP_W)
	) u_sys (
		.periph_irq(periph_irq),
		.bus(evt_bus.sys)
	);

	assign evt_bus.pmask = pmask_reg;
	assign evt_bus.map = map_reg;

	// event inputs per class
	assign evt_in = (evt_bus.gen_lines & tsec_pkg::GEN_BITS)
		| ({15'h0000, emu_sync_reg[1]} << tsec_pkg::LVL_EMU)
		| ({15'h0000, rst_sync_reg[1]} << tsec_pkg::LVL_RST)
		| ({15'h0000, nmi_sync_reg[1] | wdog_nmi} << tsec_pkg::LVL_NMI);
	assign direct_set = ({15'h0000, exc_req} << tsec_pkg::LVL_EXC)
		| (({15'h0000, swi_req} << swi_level) & tsec_pkg::GEN_BITS);

	tsec_edge_latch #(
		.W(tsec_pkg::NLEVEL)
	) u_latch (
		.clk(pclk),
		.rstn(presetn),
		.evt_in(evt_in),
		.direct_set(direct_set),
		.take_clr(take_clr),
		.wr_en(wr && sel_latch),
		.wr_sel(~cmask_eff),
		.wr_data(pwdata[15:0]),
		.latch(latch),
		.overrun(overrun)
	);

	// arbitration
	assign cmask_eff = cmask_reg | tsec_pkg::FIXED_BITS;
	assign gen_en_bits = ctrl_reg[tsec_pkg::CTRL_GEN_EN] ? tsec_pkg::ALL_BITS : ~tsec_pkg::GEN_BITS;
	assign pending = latch & cmask_eff & gen_en_bits;
	assign pend_lvl = tsec_pkg::tsec_first(pending);
	assign act_lvl = tsec_pkg::tsec_first(active_reg);
	assign pend_onehot = 16'h0001 << pend_lvl;
	assign rte_onehot = rte_valid ? (16'h0001 << rte_level) : 16'h0000;
	// an empty active set must not block level 15, which shares the empty code
	assign take = (|pending) && core_ready && ((active_reg == 16'h0000) || (pend_lvl < act_lvl));
	assign take_rst = take && (pend_lvl == tsec_pkg::LVL_RST);
	assign take_emu = take && (pend_lvl == tsec_pkg::LVL_EMU);
	assign rte_emu = rte_valid && (rte_level == tsec_pkg::LVL_EMU);
	assign take_clr = take_rst ? tsec_pkg::ALL_BITS : (take ? pend_onehot : 16'h0000);
	assign active_next = take_rst ? pend_onehot :
		((active_reg & ~rte_onehot) | (take ? pend_onehot : 16'h0000));

	// interrupt status events, set wins over clear
	assign irq_stat_next = (irq_stat_reg & ~((wr && sel_irq_stat) ? pwdata[tsec_pkg::IRQ_W-1:0] : 3'h0))
		| {overrun, rte_valid, take};

	// register decode
	assign acc = psel && penable;
	assign wr = acc && pwrite;
	assign sel_latch = (paddr == tsec_pkg::OFS_LATCH);
	assign sel_cmask = (paddr == tsec_pkg::OFS_CMASK);
	assign sel_active = (paddr == tsec_pkg::OFS_ACTIVE);
	assign sel_pmask = (paddr == tsec_pkg::OFS_PMASK);
	assign sel_pstatus = (paddr == tsec_pkg::OFS_PSTATUS);
	assign sel_irq_stat = (paddr == tsec_pkg::OFS_IRQ_STAT);
	assign sel_irq_mask = (paddr == tsec_pkg::OFS_IRQ_MASK);
	assign sel_ctrl = (paddr == tsec_pkg::OFS_CTRL);
	assign sel_map = (paddr[7:4] == tsec_pkg::OFS_MAP_HI) && (paddr[1:0] == 2'h0);
	assign hit = sel_latch | sel_cmask | sel_active | sel_pmask | sel_pstatus
		| sel_irq_stat | sel_irq_mask | sel_ctrl | sel_map;
	assign map_idx = paddr[3:2];
	assign map_word = map_reg[map_idx*32 +: 32];

	// APB answers at once
	assign pready = 1'b1;
	assign pslverr = acc && !hit;
	assign prdata = sel_latch ? {16'h0000, latch} :
		sel_cmask ? {16'h0000, cmask_eff} :
		sel_active ? {16'h0000, active_reg} :
		sel_pmask ? pmask_reg :
		sel_pstatus ? evt_bus.pstatus :
		sel_irq_stat ? {29'h0000_0000, irq_stat_reg} :
		sel_irq_mask ? {29'h0000_0000, irq_mask_reg} :
		sel_ctrl ? ctrl_reg :
		sel_map ? map_word : 32'h0000_0000;

	// outputs
	assign dispatch_valid = dispatch_valid_reg;
	assign dispatch_level = dispatch_level_reg;
	assign save_state_req = dispatch_valid_reg;
	assign core_reset = core_reset_reg;
	assign emu_mode = emu_mode_reg;
	assign resume_valid = resume_valid_reg;
	assign resume_pc = resume_pc_reg;
	assign irq = |(irq_stat_reg & irq_mask_reg);

	// pin synchronisers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nmi_sync_reg <= 2'h0;
			emu_sync_reg <= 2'h0;
			rst_sync_reg <= 2'h0;
		end else begin
			nmi_sync_reg <= {nmi_sync_reg[0], nmi_pin};
			emu_sync_reg <= {emu_sync_reg[0], emu_pin};
			rst_sync_reg <= {rst_sync_reg[0], reset_pin};
		end
	end

	// software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmask_reg <= tsec_pkg::CMASK_RST;
			pmask_reg <= tsec_pkg::PMASK_RST;
			map_reg <= tsec_pkg::MAP_RST;
			ctrl_reg <= tsec_pkg::CTRL_RST;
			irq_mask_reg <= 3'h0;
			irq_stat_reg <= 3'h0;
		end else begin
			irq_stat_reg <= irq_stat_next;
			if (wr && sel_cmask) begin
				cmask_reg <= pwdata[15:0] & tsec_pkg::GEN_BITS;
			end
			if (wr && sel_pmask) begin
				pmask_reg <= pwdata;
			end
			if (wr && sel_map) begin
				map_reg[map_idx*32 +: 32] <= pwdata;
			end
			if (wr && sel_ctrl) begin
				ctrl_reg <= pwdata & tsec_pkg::CTRL_RST;
			end
			if (wr && sel_irq_mask) begin
				irq_mask_reg <= pwdata[tsec_pkg::IRQ_W-1:0];
			end
		end
	end

	// active bits and sequencer handshake
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_reg <= 16'h0000;
			dispatch_valid_reg <= 1'b0;
			dispatch_level_reg <= tsec_pkg::LVL_NONE;
			core_reset_reg <= 1'b0;
			emu_mode_reg <= 1'b0;
			resume_valid_reg <= 1'b0;
			resume_pc_reg <= 32'h0000_0000;
		end else begin
			active_reg <= active_next;
			dispatch_valid_reg <= take;
			core_reset_reg <= take_rst;
			resume_valid_reg <= rte_valid;
			if (take) begin
				dispatch_level_reg <= pend_lvl;
			end
			if (take_emu) begin
				emu_mode_reg <= 1'b1;
			end else if (rte_emu) begin
				emu_mode_reg <= 1'b0;
			end
			if (rte_valid) begin
				resume_pc_reg <= ret_addr_reg[rte_level];
			end
		end
	end

	// return address per level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < tsec_pkg::NLEVEL; i++) begin
				ret_addr_reg[i] <= 32'h0000_0000;
			end
		end else if (take) begin
			ret_addr_reg[pend_lvl] <= core_pc;
		end
	end
endmodule
`default_nettype wire

// ### testbench/tsec_chk.sv
// port assertions for the event controller
`timescale 1ns/1ps
`default_nettype none
module tsec_chk (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// events and sequencer
	input wire logic wdog_nmi,
	input wire logic rte_valid,
	input wire logic dispatch_valid,
	input wire logic [3:0] dispatch_level,
	input wire logic save_state_req,
	input wire logic core_reset,
	input wire logic emu_mode,
	input wire logic resume_valid
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_save; dispatch_valid == save_state_req; endproperty
	a_save: assert property (p_save) else $error("save not with take");
	property p_rst; core_reset |-> dispatch_valid && dispatch_level == tsec_pkg::LVL_RST; endproperty
	a_rst: assert property (p_rst) else $error("core reset without reset take");
	property p_emu; $rose(emu_mode) |-> dispatch_valid && dispatch_level == tsec_pkg::LVL_EMU; endproperty
	a_emu: assert property (p_emu) else $error("emulation entered without take");
	property p_hold; emu_mode && !rte_valid |=> emu_mode; endproperty
	a_hold: assert property (p_hold) else $error("emulation left without return");
	property p_ret; rte_valid |=> resume_valid; endproperty
	a_ret: assert property (p_ret) else $error("no resume after return");
	property p_lvl; dispatch_valid |-> dispatch_level inside {[4'h0:4'h3], [4'h7:4'hF]}; endproperty
	a_lvl: assert property (p_lvl) else $error("take of unknown class");
	property p_nest; dispatch_valid |=> !dispatch_valid || dispatch_level < $past(dispatch_level); endproperty
	a_nest: assert property (p_nest) else $error("nested take not higher");
	property p_lat; $rose(wdog_nmi) |-> (!(dispatch_valid && dispatch_level == tsec_pkg::LVL_NMI)) [*3]; endproperty
	a_lat: assert property (p_lat) else $error("nmi taken too early");
endmodule
`default_nettype wire

// ### testbench/tsec_seq_model.sv
// sequencer model: ready, return address and return from event
`timescale 1ns/1ps
`default_nettype none
module tsec_seq_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// from the controller
	input wire logic dispatch_valid,
	input wire logic [3:0] dispatch_level,
	input wire logic stall,
	// to the controller
	output logic core_ready,
	output logic [31:0] core_pc,
	output logic rte_valid,
	output logic [3:0] rte_level
);
	logic [3:0] lv[$];
	logic [31:0] pc[$];
	logic [31:0] pc_prev, last_pc;
	assign core_ready = !stall;
	initial begin
		core_pc = 32'h0;
		rte_valid = 0;
		rte_level = 4'h0;
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_pc <= 32'h0000_1000;
			pc_prev <= 32'h0;
			lv.delete();
			pc.delete();
		end else begin
			pc_prev <= core_pc;
			core_pc <= core_pc + 32'h4;
			if (dispatch_valid) begin
				lv.push_back(dispatch_level);
				pc.push_back(pc_prev);
			end
		end
	end
	// return from the innermost taken event
	task ret();
		logic [3:0] l;
		@(negedge pclk);
		l = lv.pop_back();
		last_pc = pc.pop_back();
		@(posedge pclk);
		rte_level <= l;
		rte_valid <= 1;
		@(posedge pclk);
		rte_valid <= 0;
		rte_level <= ~l;
	endtask
endmodule
`default_nettype wire

// ### testbench/tsec_tb_top.sv
// bench for the two-stage event controller
`timescale 1ns/1ps
`default_nettype none
module tsec_tb_top;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
	logic wdog_nmi = 0, exc_req = 0, swi_req = 0, stall = 0;
	logic [2:0] pins = 3'h0;
	logic [3:0] swi_level = 4'h0, rte_level, dispatch_level;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, periph_irq = 32'h0, prdata, q, core_pc, resume_pc;
	logic pready, pslverr, core_ready, rte_valid, dispatch_valid, save_state_req;
	logic core_reset, emu_mode, resume_valid, irq;
	int fail_count = 0, num_checks = 0, n;
	always #10 pclk = ~pclk;
	tsec_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.periph_irq(periph_irq), .wdog_nmi(wdog_nmi), .nmi_pin(pins[2]), .emu_pin(pins[0]),
		.reset_pin(pins[1]), .exc_req(exc_req), .swi_req(swi_req), .swi_level(swi_level),
		.core_ready(core_ready), .core_pc(core_pc), .rte_valid(rte_valid), .rte_level(rte_level),
		.dispatch_valid(dispatch_valid), .dispatch_level(dispatch_level), .save_state_req(save_state_req),
		.core_reset(core_reset), .emu_mode(emu_mode), .resume_valid(resume_valid), .resume_pc(resume_pc),
		.irq(irq));
	tsec_seq_model m (.pclk(pclk), .presetn(presetn), .dispatch_valid(dispatch_valid),
		.dispatch_level(dispatch_level), .stall(stall), .core_ready(core_ready), .core_pc(core_pc),
		.rte_valid(rte_valid), .rte_level(rte_level));
	task chk(input string s, input logic [31:0] x, input logic [31:0] g);
		num_checks++;
		if (g !== x) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", s, x, g);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1);
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1, a, d);
	endtask
	task rd(input string s, input logic [7:0] a, input logic [31:0] x);
		apb(0, a, 32'h0);
		chk(s, x, q);
	endtask
	task wt(input logic [3:0] x);
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (dispatch_valid !== 1 && n < 40);
		chk("take", 32'({x, 1'b1}), 32'({dispatch_level, dispatch_valid}));
	endtask
	task rt();
		m.ret();
		@(negedge pclk);
		chk("resume", m.last_pc, resume_valid === 1 ? resume_pc : 32'hX);
	endtask
	task ik(input logic x);
		@(negedge pclk);
		chk("irq", 32'(x), 32'(irq));
	endtask
	task conclude();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		#100us;
		fail_count++;
		conclude();
	end
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1;
		rd("cmask", 8'h04, 32'h0000_000F);
		rd("ctrl", 8'h1C, 32'h0000_0001);
		rd("map", 8'h3C, 32'hDDD7_7777);
		apb(0, 8'h20, 32'h0);
		chk("slverr", 32'h1, 32'(e));
		wr(8'h04, 32'h0000_2200);
		wr(8'h18, 32'h0000_0007);
		@(posedge pclk);
		periph_irq <= 32'h2000_0000;
		rd("pstat", 8'h10, 32'h2000_0000);
		rd("latch", 8'h00, 32'h0000_0000);
		@(posedge pclk);
		periph_irq <= 32'h0;
		wr(8'h0C, 32'hE000_0000);
		for (int i = 29; i < 32; i++) begin
			@(posedge pclk);
			periph_irq <= 32'h1 << i;
			wt(4'hD);
			chk("latency", 32'h1, 32'(n > 3));
			rt();
			@(posedge pclk);
			periph_irq <= 32'h0;
		end
		rd("irq_stat", 8'h14, 32'h0000_0003);
		ik(1);
		wr(8'h18, 32'h0);
		ik(0);
		wr(8'h18, 32'h7);
		ik(1);
		wr(8'h14, 32'h7);
		ik(0);
		// exception nests over an active general level
		@(posedge pclk);
		periph_irq <= 32'h2000_0000;
		wt(4'hD);
		@(posedge pclk);
		exc_req <= 1;
		@(posedge pclk);
		exc_req <= 0;
		wt(4'h3);
		rd("active", 8'h08, 32'h0000_2008);
		rt();
		rt();
		rd("active", 8'h08, 32'h0000_0000);
		// core mask blocks a latched event
		wr(8'h04, 32'h0);
		@(posedge pclk);
		periph_irq <= 32'h0;
		@(posedge pclk);
		periph_irq <= 32'h2000_0000;
		repeat (5) @(negedge pclk);
		rd("latch", 8'h00, 32'h0000_2000);
		wr(8'h04, 32'h0000_2200);
		wt(4'hD);
		rd("latch", 8'h00, 32'h0000_0000);
		rt();
		// three classes pending while the core stalls
		@(posedge pclk);
		stall <= 1;
		wdog_nmi <= 1;
		exc_req <= 1;
		swi_req <= 1;
		swi_level <= 4'h9;
		@(posedge pclk);
		exc_req <= 0;
		swi_req <= 0;
		wdog_nmi <= 0;
		rd("latch", 8'h00, 32'h0000_020C);
		@(posedge pclk);
		stall <= 0;
		wt(4'h2);
		rt();
		wt(4'h3);
		rt();
		wt(4'h9);
		rt();
		// emulation, reset and nmi pins
		for (int i = 0; i < 3; i++) begin
			@(posedge pclk);
			pins[i] <= 1;
			wt(i[3:0]);
			chk("mode", 32'({i == 0, i == 1}), 32'({emu_mode, core_reset}));
			rt();
			@(posedge pclk);
			pins[i] <= 0;
		end
		chk("emu", 32'h0, 32'(emu_mode));
		// global general enable off holds level 15 latched, then lets it in
		wr(8'h1C, 32'h0);
		wr(8'h04, 32'h0000_A200);
		@(posedge pclk);
		swi_req <= 1;
		swi_level <= 4'hF;
		@(posedge pclk);
		swi_req <= 0;
		rd("latch", 8'h00, 32'h0000_8000);
		wr(8'h1C, 32'h1);
		wt(4'hF);
		rt();
		conclude();
	end
endmodule
bind tsec_top tsec_chk u_chk (.pclk(pclk), .presetn(presetn), .wdog_nmi(wdog_nmi), .rte_valid(rte_valid),
	.dispatch_valid(dispatch_valid), .dispatch_level(dispatch_level), .save_state_req(save_state_req),
	.core_reset(core_reset), .emu_mode(emu_mode), .resume_valid(resume_valid));
`default_nettype wire
